// ==== iod_consts.svh ====
`ifndef IOD_CONSTS_SVH
`define IOD_CONSTS_SVH
// ----------------------------------------
// Register offsets (register index, 5 bits)
// ----------------------------------------
`define IOD_OFS_PWM0 5'h00
`define IOD_OFS_PWM1 5'h01
`define IOD_OFS_LED 5'h02
`define IOD_OFS_FORCE 5'h03
`define IOD_OFS_CHG 5'h04
`define IOD_OFS_IVL 5'h05
`define IOD_OFS_DECIM 5'h06
`define IOD_OFS_BTN 5'h07
`define IOD_OFS_FWV 5'h08
`define IOD_OFS_HWV 5'h09
`define IOD_OFS_CFG 5'h0A
`define IOD_OFS_ERR 5'h0B
`define IOD_OFS_GOOD 5'h0C
`define IOD_OFS_HOLD 5'h0D
`define IOD_OFS_TXF 5'h0E
`define IOD_OFS_TEMP 5'h0F
`define IOD_OFS_DBM 5'h10
`define IOD_OFS_SEL10 5'h11
`define IOD_OFS_SEL11 5'h12
`define IOD_OFS_SEL5 5'h13
`define IOD_OFS_DIGEN 5'h14
`define IOD_OFS_ANAEN 5'h15
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define IOD_RST_DECIM 8'h01
`define IOD_RST_HOLD 8'h20
`define IOD_RST_SEL10 3'h1
`define IOD_RST_SEL11 3'h0
`define IOD_RST_SEL5 3'h1
`define IOD_PWM_MAX 10'h3FF
`define IOD_SAT_MAX 16'hFFFF
`define IOD_BTN_MAX 3'h4
`define IOD_SEL_PWM 3'h2
`define IOD_SEL_RSSI 3'h1
`define IOD_SEL_LED 3'h1
// ----------------------------------------
// Timing
// ----------------------------------------
`define IOD_CLK_NS 40
`define IOD_MS_NS 1000000
`define IOD_LED_COORD_MS 500
`define IOD_LED_NODE_MS 250
`define IOD_LED_UNIT_MS 10
`define IOD_HOLD_UNIT_MS 100
`endif

// ==== iod_pkg.sv ====
package iod_pkg;
  // Why a sample was produced
  typedef enum logic [1:0] {
    IOD_SRC_NONE,
    IOD_SRC_FORCE,
    IOD_SRC_CHANGE,
    IOD_SRC_PERIODIC
  } iod_src_e;
  // One I/O sample as handed to the framing logic
  typedef struct packed {
    logic valid;
    iod_src_e source;
    logic [12:0] digital;
    logic [12:0] analog_mask;
  } iod_sample_s;
  // Reception event with its strength
  typedef struct packed {
    logic valid;
    logic [7:0] strength;
  } iod_rx_s;
endpackage

// ==== iod_core.sv ====
`include "iod_consts.svh"
// How it works
// R1: Two 10-bit PWM levels, reset zero
// R2: Host selects PWM function before level
// R3: Blink 500ms coordinator, 250ms otherwise when zero
// R4: Nonzero blink setting times 10ms
// R5: Force command samples all enabled lines
// R6: Masked digital line change triggers sample
// R7: Host zeroes mask bits above 12
// R8: Periodic only with interval and enabled lines
// R9: Interval is 16-bit milliseconds, default zero
// R10: Periodic sampling every Nth wake cycle
// R11: Button command performs count presses
// R12: Saturating integrity-error counter
// R13: Saturating valid-frame counter
// R14: Saturating retry-exhaust counter
// R15: Signal output held setting times 100ms
// R16: Signed 16-bit temperature readback
// R17: Last hop strength in -dBm
// R18: Read-only 32-bit firmware version
// R19: Read-only 16-bit hardware version
// R20: Configuration check code from settings
// R21: Line 10 PWM at 2, signal at 1
// R22: LED drives line 5 at select 1
// R23: Statistics counters clear on reset
module iod_core #(
  parameter int MS_CYC = `IOD_MS_NS / `IOD_CLK_NS,
  parameter logic [31:0] FW_VERSION = 32'h00000001, // Arbitrary value
  parameter logic [15:0] HW_VERSION = 16'h0001 // Arbitrary value
) (
  input wire logic core_clk, // Module clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [4:0] reg_addr, // Register index
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [12:0] line_in, // Digital line levels
  input wire logic sleep_coord, // Node is sleep coordinator
  input wire logic sleep_mode, // Cyclic sleep in use
  input wire logic wake_start, // Start of wake cycle pulse
  input wire logic rx_error_ev, // Packet with integrity error
  input wire logic rx_good_ev, // Frame with valid header
  input wire logic tx_fail_ev, // Retries exhausted
  input wire iod_pkg::iod_rx_s rx_info, // Reception with strength
  input wire logic [15:0] temp_in, // Signed temperature, Celsius
  output iod_pkg::iod_sample_s sample, // Sample out
  output logic [2:0] button_count, // Simulated presses
  output logic button_pulse, // Button action strobe
  output logic pwm0_out, // Line 10 output
  output logic pwm1_out, // Line 11 output
  output logic led_out, // Line 5 output
  output logic led_drive // Line 5 driven by blinker
);
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  logic [9:0] pwm0_level_q, pwm_one_level_q;
  logic [7:0] led_blink_period_q, decim_q, rssi_hold_time_q, last_hop_strength_q;
  logic [15:0] change_detect_mask_q, sample_interval_q, module_temperature_q;
  logic [2:0] line10_function_select_q, line11_function_select_q, line5_function_select_q;
  logic [12:0] dig_en_q, ana_en_q;
  logic force_sample_cmd;
  logic wr_hit;

  // Config checksum over all writable settings
  function automatic logic [27:0] cfg_code(input logic [9:0] a, input logic [9:0] b,
                                           input logic [7:0] c, input logic [15:0] d,
                                           input logic [15:0] e, input logic [7:0] f,
                                           input logic [7:0] g, input logic [12:0] h,
                                           input logic [12:0] i, input logic [8:0] s);
    cfg_code = {18'h00000, a} ^ {8'h00, b, 10'h000} ^ {c, 20'h00000}
             ^ {12'h000, d} ^ {e, 12'h000} ^ {4'h0, f, g, 8'h00}
             ^ {15'h0000, h} ^ {2'h0, i, 13'h0000} ^ {19'h00000, s};
  endfunction

  assign wr_hit = ce && reg_wr;
  assign force_sample_cmd = wr_hit && reg_addr == `IOD_OFS_FORCE;

  // Software writable settings
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwm0_level_q <= 10'h000;
      pwm_one_level_q <= 10'h000;
      led_blink_period_q <= 8'h00;
      change_detect_mask_q <= 16'h0000;
      sample_interval_q <= 16'h0000;
      decim_q <= `IOD_RST_DECIM;
      rssi_hold_time_q <= `IOD_RST_HOLD;
      line10_function_select_q <= `IOD_RST_SEL10;
      line11_function_select_q <= `IOD_RST_SEL11;
      line5_function_select_q <= `IOD_RST_SEL5;
      dig_en_q <= 13'h0000;
      ana_en_q <= 13'h0000;
    end else if (wr_hit) begin
      case (reg_addr)
        `IOD_OFS_PWM0: pwm0_level_q <= reg_wdata[9:0]; // R1
        `IOD_OFS_PWM1: pwm_one_level_q <= reg_wdata[9:0]; // R1
        `IOD_OFS_LED: led_blink_period_q <= reg_wdata[7:0];
        `IOD_OFS_CHG: change_detect_mask_q <= reg_wdata[15:0];
        `IOD_OFS_IVL: sample_interval_q <= reg_wdata[15:0]; // R9
        `IOD_OFS_DECIM: decim_q <= reg_wdata[7:0];
        `IOD_OFS_HOLD: rssi_hold_time_q <= reg_wdata[7:0];
        `IOD_OFS_SEL10: line10_function_select_q <= reg_wdata[2:0];
        `IOD_OFS_SEL11: line11_function_select_q <= reg_wdata[2:0];
        `IOD_OFS_SEL5: line5_function_select_q <= reg_wdata[2:0];
        `IOD_OFS_DIGEN: dig_en_q <= reg_wdata[12:0];
        `IOD_OFS_ANAEN: ana_en_q <= reg_wdata[12:0];
        default: ;
      endcase
    end
  end

  // Button command; counts above four give no pulse but still load button_count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      button_pulse <= 1'b0;
      button_count <= 3'h0;
    end else if (ce) begin
      button_pulse <= wr_hit && reg_addr == `IOD_OFS_BTN
                      && reg_wdata[31:0] <= {29'h0, `IOD_BTN_MAX}; // R11
      if (wr_hit && reg_addr == `IOD_OFS_BTN) begin
        button_count <= reg_wdata[2:0]; // R11
      end
    end
  end

  // ----------------------------------------
  // Millisecond time base
  // ----------------------------------------
  logic [15:0] pre_q;
  logic ms_tick;
  assign ms_tick = ce && pre_q == 16'(MS_CYC - 1);

  // Prescaler from core clock to 1 ms
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 16'h0000;
    end else if (ce) begin
      pre_q <= ms_tick ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Statistics and readback values
  // ----------------------------------------
  logic [15:0] stat_q [3];
  logic [2:0] stat_ev;
  assign stat_ev = {tx_fail_ev, rx_good_ev, rx_error_ev};

  // Saturating counters, one per event kind
  for (genvar g = 0; g < 3; g++) begin : g_stat
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        stat_q[g] <= 16'h0000; // R23
      end else if (ce && stat_ev[g] && stat_q[g] != `IOD_SAT_MAX) begin
        stat_q[g] <= stat_q[g] + 16'h0001; // R12 R13 R14
      end
    end
    a_stat_holds: assert property (@(posedge core_clk) disable iff (!rstn) // R12 R13 R14
      stat_q[g] == `IOD_SAT_MAX |=> stat_q[g] == `IOD_SAT_MAX)
      else $error("statistics counter left saturation");
  end

  // Sampled temperature and last hop strength
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      module_temperature_q <= 16'h0000;
      last_hop_strength_q <= 8'h00;
    end else if (ce) begin
      module_temperature_q <= temp_in; // R16
      if (rx_info.valid) begin
        last_hop_strength_q <= rx_info.strength; // R17
      end
    end
  end

  // Register read, answered one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `IOD_OFS_PWM0: reg_rdata <= {22'h0, pwm0_level_q};
          `IOD_OFS_PWM1: reg_rdata <= {22'h0, pwm_one_level_q}; // R1
          `IOD_OFS_LED: reg_rdata <= {24'h0, led_blink_period_q};
          `IOD_OFS_CHG: reg_rdata <= {16'h0, change_detect_mask_q};
          `IOD_OFS_IVL: reg_rdata <= {16'h0, sample_interval_q};
          `IOD_OFS_DECIM: reg_rdata <= {24'h0, decim_q};
          `IOD_OFS_FWV: reg_rdata <= FW_VERSION; // R18
          `IOD_OFS_HWV: reg_rdata <= {16'h0, HW_VERSION}; // R19
          `IOD_OFS_CFG: reg_rdata <= {4'h0, cfg_code(pwm0_level_q, pwm_one_level_q, // R20
            led_blink_period_q, change_detect_mask_q, sample_interval_q, decim_q,
            rssi_hold_time_q, dig_en_q, ana_en_q, {line10_function_select_q,
            line11_function_select_q, line5_function_select_q})};
          `IOD_OFS_ERR: reg_rdata <= {16'h0, stat_q[0]};
          `IOD_OFS_GOOD: reg_rdata <= {16'h0, stat_q[1]};
          `IOD_OFS_HOLD: reg_rdata <= {24'h0, rssi_hold_time_q};
          `IOD_OFS_TXF: reg_rdata <= {16'h0, stat_q[2]};
          `IOD_OFS_TEMP: reg_rdata <= {16'h0, module_temperature_q}; // R16
          `IOD_OFS_DBM: reg_rdata <= {24'h0, last_hop_strength_q}; // R17
          `IOD_OFS_SEL10: reg_rdata <= {29'h0, line10_function_select_q};
          `IOD_OFS_SEL11: reg_rdata <= {29'h0, line11_function_select_q};
          `IOD_OFS_SEL5: reg_rdata <= {29'h0, line5_function_select_q};
          `IOD_OFS_DIGEN: reg_rdata <= {19'h0, dig_en_q};
          `IOD_OFS_ANAEN: reg_rdata <= {19'h0, ana_en_q};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // PWM and signal-strength output
  // ----------------------------------------
  logic [9:0] pwm_cnt_q;
  logic [15:0] hold_q;
  logic rssi_pwm;

  // Free running PWM phase; a level of 0x3FF is fully on save one slot
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_cnt_q <= 10'h000;
    end else if (ce) begin
      pwm_cnt_q <= pwm_cnt_q + 10'h001;
    end
  end

  // Hold timer in ms, reloaded by each reception
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 16'h0000;
    end else if (ce) begin
      if (rx_info.valid) begin
        hold_q <= 16'(rssi_hold_time_q * `IOD_HOLD_UNIT_MS); // R15
      end else if (ms_tick && hold_q != 16'h0000) begin
        hold_q <= hold_q - 16'h0001; // R15
      end
    end
  end

  assign rssi_pwm = hold_q != 16'h0000 && pwm_cnt_q < {last_hop_strength_q, 2'b00};

  // Line routing by function select
  always_comb begin
    pwm0_out = 1'b0;
    if (line10_function_select_q == `IOD_SEL_PWM) begin
      pwm0_out = pwm_cnt_q < pwm0_level_q; // R21
    end else if (line10_function_select_q == `IOD_SEL_RSSI) begin
      pwm0_out = rssi_pwm; // R21
    end
    pwm1_out = line11_function_select_q == `IOD_SEL_PWM && pwm_cnt_q < pwm_one_level_q;
  end

  a_pwm_zero: assert property (@(posedge core_clk) disable iff (!rstn) // R21
    line10_function_select_q != `IOD_SEL_PWM && line10_function_select_q != `IOD_SEL_RSSI
    |-> !pwm0_out)
    else $error("line 10 active with no PWM function");

  a_hold_load: assert property (@(posedge core_clk) disable iff (!rstn) // R15
    ce && rx_info.valid |=> hold_q == 16'($past(rssi_hold_time_q) * 100))
    else $error("hold timer not loaded on reception");

  // ----------------------------------------
  // Association LED blinker
  // ----------------------------------------
  logic [11:0] led_cnt_q, led_half;
  logic led_q;

  always_comb begin
    if (led_blink_period_q == 8'h00) begin
      led_half = sleep_coord ? 12'(`IOD_LED_COORD_MS) : 12'(`IOD_LED_NODE_MS); // R3
    end else begin
      led_half = 12'(led_blink_period_q * `IOD_LED_UNIT_MS); // R4
    end
  end

  // Toggle each half period; restart if the period shrinks under the count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      led_cnt_q <= 12'h000;
      led_q <= 1'b0;
    end else if (ms_tick) begin
      if (led_cnt_q >= led_half - 12'h001) begin
        led_cnt_q <= 12'h000;
        led_q <= !led_q; // R3 R4
      end else begin
        led_cnt_q <= led_cnt_q + 12'h001;
      end
    end
  end

  assign led_drive = line5_function_select_q == `IOD_SEL_LED; // R22
  assign led_out = led_drive && led_q; // R22

  a_led_hold: assert property (@(posedge core_clk) disable iff (!rstn) // R3 R4
    ms_tick && led_cnt_q < led_half - 12'h001 |=> led_q == $past(led_q))
    else $error("LED toggled before its half period");

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  logic [12:0] line_prev_q, changed;
  logic [7:0] wake_cnt_q;
  logic window_q, per_en, per_due;
  logic [15:0] ivl_cnt_q;

  assign changed = (line_in ^ line_prev_q) & change_detect_mask_q[12:0] & dig_en_q; // R6
  assign per_en = sample_interval_q != 16'h0000 && (dig_en_q | ana_en_q) != 13'h0000; // R8
  assign per_due = per_en && window_q && ms_tick && ivl_cnt_q >= sample_interval_q - 16'h0001;

  // Previous line levels for edge detection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_prev_q <= 13'h0000;
    end else if (ce) begin
      line_prev_q <= line_in;
    end
  end

  // Wake cycle decimation; window opens on every Nth wake
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_cnt_q <= 8'h00;
      window_q <= 1'b0;
    end else if (ce && wake_start) begin
      if (wake_cnt_q + 8'h01 >= decim_q) begin
        wake_cnt_q <= 8'h00;
        window_q <= 1'b1; // R10
      end else begin
        wake_cnt_q <= wake_cnt_q + 8'h01;
        window_q <= 1'b0; // R10
      end
    end else if (ce && !sleep_mode) begin
      window_q <= 1'b1;
    end
  end

  // Millisecond interval counter, cleared to zero while disabled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ivl_cnt_q <= 16'h0000;
    end else if (ce) begin
      if (!per_en || !window_q || per_due) begin
        ivl_cnt_q <= 16'h0000;
      end else if (ms_tick) begin
        ivl_cnt_q <= ivl_cnt_q + 16'h0001; // R9
      end
    end
  end

  // Sample output; force beats change beats periodic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample <= '0;
    end else if (ce) begin
      sample.valid <= force_sample_cmd || changed != 13'h0000 || per_due;
      sample.digital <= line_in & dig_en_q; // R5
      sample.analog_mask <= ana_en_q; // R5
      if (force_sample_cmd) begin
        sample.source <= iod_pkg::IOD_SRC_FORCE; // R5
      end else if (changed != 13'h0000) begin
        sample.source <= iod_pkg::IOD_SRC_CHANGE; // R6
      end else if (per_due) begin
        sample.source <= iod_pkg::IOD_SRC_PERIODIC; // R8
      end else begin
        sample.source <= iod_pkg::IOD_SRC_NONE;
      end
    end
  end

  a_force_sample: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    force_sample_cmd |=> sample.valid && sample.source == iod_pkg::IOD_SRC_FORCE)
    else $error("force command gave no sample");

  a_change_sample: assert property (@(posedge core_clk) disable iff (!rstn) // R6
    ce && changed != 13'h0000 |=> sample.valid)
    else $error("masked change gave no sample");

  a_no_periodic: assert property (@(posedge core_clk) disable iff (!rstn) // R8
    sample_interval_q == 16'h0000 && ce ##1 !force_sample_cmd && $stable(sample_interval_q)
    |-> sample.source != iod_pkg::IOD_SRC_PERIODIC)
    else $error("periodic sample with zero interval");

  a_button_range: assert property (@(posedge core_clk) disable iff (!rstn) // R11
    button_pulse |-> button_count <= `IOD_BTN_MAX)
    else $error("button count out of range");

  a_read_latency: assert property (@(posedge core_clk) disable iff (!rstn) // R19
    ce && reg_rd && reg_addr == `IOD_OFS_HWV |=> reg_rdata == {16'h0, HW_VERSION})
    else $error("hardware version read wrong");
endmodule

// ==== iod_host.sv ====
`include "iod_consts.svh"
// Host side of the register port: one-cycle strobes, no wait states
module iod_host (
  input wire logic core_clk, // Module clock
  output logic [4:0] reg_addr, // Register index
  output logic [31:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    reg_addr = 5'h1F;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Data flipped after the strobe so a stale word never looks valid
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read word only stands in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // Select the PWM function before setting its level
  task automatic set_pwm(input logic line, input logic [9:0] lvl);
    wr(line ? `IOD_OFS_SEL11 : `IOD_OFS_SEL10, {29'h0, `IOD_SEL_PWM});
    wr(line ? `IOD_OFS_PWM1 : `IOD_OFS_PWM0, {22'h0, lvl});
  endtask
  // Bits above line 12 always written as zero
  task automatic set_mask(input logic [12:0] m);
    wr(`IOD_OFS_CHG, {19'h0, m});
  endtask
endmodule

// ==== io_sampling_and_link_diagnostics_test.sv ====
`include "iod_consts.svh"
module io_sampling_and_link_diagnostics_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FWV = 32'h0000ABCD; // Arbitrary value
  localparam logic [15:0] HWV = 16'h0042; // Arbitrary value
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, c0, c1;
  logic reg_wr, reg_rd, sleep_coord = 1'b0, sleep_mode = 1'b0, wake_start = 1'b0;
  logic rx_error_ev = 1'b0, rx_good_ev = 1'b0, tx_fail_ev = 1'b0;
  logic [12:0] line_in = 13'h1234;
  logic [15:0] temp_in = 16'hFF74;
  iod_pkg::iod_rx_s rx_info = '0;
  iod_pkg::iod_sample_s sample, last_smp;
  logic [2:0] button_count;
  logic button_pulse, pwm0_out, pwm1_out, led_out, led_drive;
  int failures = 0, tests_run = 0, nsamp = 0, npulse = 0, n0, h;
  // ----------------------------------------
  // Clock, device, host
  // ----------------------------------------
  always #20 core_clk = ~core_clk;
  iod_core #(.MS_CYC(4), .FW_VERSION(FWV), .HW_VERSION(HWV)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_in(line_in), .sleep_coord(sleep_coord), .sleep_mode(sleep_mode),
    .wake_start(wake_start), .rx_error_ev(rx_error_ev), .rx_good_ev(rx_good_ev),
    .tx_fail_ev(tx_fail_ev), .rx_info(rx_info), .temp_in(temp_in), .sample(sample),
    .button_count(button_count), .button_pulse(button_pulse), .pwm0_out(pwm0_out),
    .pwm1_out(pwm1_out), .led_out(led_out), .led_drive(led_drive));
  iod_host i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Sample and button pulses are one cycle long, so they are counted here
  always @(posedge core_clk) begin
    if (sample.valid === 1'b1) begin
      last_smp <= sample;
      nsamp <= nsamp + 1;
    end
    if (button_pulse === 1'b1) npulse <= npulse + 1;
  end
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input string name, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.rd(a, d);
    check(name, d, exp);
  endtask
  // Second gap between LED toggles; the first may be a partial period
  task automatic led_gap(input int exp);
    logic v;
    int n;
    n = 0;
    repeat (2) begin
      v = led_out;
      n = 0;
      while (led_out === v && n < 5000) begin
        @(posedge core_clk);
        n++;
      end
    end
    check("led gap", 32'(n >= exp - 1 && n <= exp + 1), 32'h1);
  endtask
  task automatic count_hi(input logic ln, input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1;
      if ((ln ? pwm1_out : pwm0_out) === 1'b1) hi++;
    end
  endtask
  // One wake cycle start, one cycle long
  task automatic pulse_wake;
    @(posedge core_clk);
    wake_start <= 1'b1;
    @(posedge core_clk);
    wake_start <= 1'b0;
  endtask
  task automatic close_out;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the saturation run
  initial begin
    #4000000;
    failures++;
    close_out();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rchk("pwm0 rst", `IOD_OFS_PWM0, 32'h0);
    rchk("ivl rst", `IOD_OFS_IVL, 32'h0);
    rchk("decim rst", `IOD_OFS_DECIM, {24'h0, `IOD_RST_DECIM});
    rchk("hold rst", `IOD_OFS_HOLD, {24'h0, `IOD_RST_HOLD});
    rchk("err rst", `IOD_OFS_ERR, 32'h0);
    rchk("good rst", `IOD_OFS_GOOD, 32'h0);
    rchk("txf rst", `IOD_OFS_TXF, 32'h0);
    i_host.wr(`IOD_OFS_FWV, 32'h12345678);
    i_host.wr(`IOD_OFS_HWV, 32'h00005555);
    rchk("fw", `IOD_OFS_FWV, FWV);
    rchk("hw", `IOD_OFS_HWV, {16'h0, HWV});
    rchk("unmapped", 5'h1F, 32'h0);
    rchk("temp", `IOD_OFS_TEMP, 32'h0000FF74);
    $display("test reset values done");
    // PWM level readback on line 11 and duty on lines 10 and 11
    i_host.set_pwm(1'b1, `IOD_PWM_MAX);
    rchk("pwm1", `IOD_OFS_PWM1, {22'h0, `IOD_PWM_MAX});
    i_host.set_pwm(1'b0, 10'h100);
    count_hi(1'b0, 1024, h);
    check("pwm0 duty", 32'(h), 32'd256);
    count_hi(1'b1, 1024, h);
    check("pwm1 duty", 32'(h), 32'd1023);
    $display("test pwm done");
    // Force sample of enabled lines
    i_host.wr(`IOD_OFS_DIGEN, 32'h00000F0F);
    i_host.wr(`IOD_OFS_ANAEN, 32'h00000003);
    repeat (3) @(posedge core_clk);
    n0 = nsamp;
    i_host.wr(`IOD_OFS_FORCE, 32'h0);
    repeat (2) @(posedge core_clk);
    check("force cnt", 32'(nsamp - n0), 32'd1);
    check("force src", 32'(last_smp.source), 32'(iod_pkg::IOD_SRC_FORCE));
    check("force dig", {19'h0, last_smp.digital}, 32'h0204);
    check("force ana", {19'h0, last_smp.analog_mask}, 32'h0003);
    // Masked line changes; an unmasked one stays silent
    i_host.set_mask(13'h0001);
    n0 = nsamp;
    line_in <= 13'h1235;
    repeat (3) @(posedge core_clk);
    check("chg cnt", 32'(nsamp - n0), 32'd1);
    check("chg src", 32'(last_smp.source), 32'(iod_pkg::IOD_SRC_CHANGE));
    check("chg dig", {19'h0, last_smp.digital}, 32'h0205);
    line_in <= 13'h1335;
    repeat (3) @(posedge core_clk);
    check("chg masked", 32'(nsamp - n0), 32'd1);
    $display("test sampling done");
    // Periodic at 3 ms, then off by interval and by enables
    i_host.wr(`IOD_OFS_IVL, 32'h3);
    n0 = nsamp;
    repeat (120) @(posedge core_clk);
    check("per cnt", 32'(nsamp - n0 >= 9 && nsamp - n0 <= 11), 32'h1);
    check("per src", 32'(last_smp.source), 32'(iod_pkg::IOD_SRC_PERIODIC));
    i_host.wr(`IOD_OFS_DECIM, 32'h2);
    sleep_mode <= 1'b1;
    pulse_wake();
    repeat (2) @(posedge core_clk);
    n0 = nsamp;
    repeat (60) @(posedge core_clk);
    check("no wake", 32'(nsamp - n0), 32'd0);
    pulse_wake();
    n0 = nsamp;
    repeat (60) @(posedge core_clk);
    check("nth wake", 32'(nsamp - n0 >= 4 && nsamp - n0 <= 5), 32'h1);
    sleep_mode <= 1'b0;
    i_host.wr(`IOD_OFS_DIGEN, 32'h0);
    i_host.wr(`IOD_OFS_ANAEN, 32'h0);
    repeat (2) @(posedge core_clk);
    n0 = nsamp;
    repeat (60) @(posedge core_clk);
    check("no lines", 32'(nsamp - n0), 32'd0);
    i_host.wr(`IOD_OFS_DIGEN, 32'h1);
    i_host.wr(`IOD_OFS_IVL, 32'h0);
    n0 = nsamp;
    repeat (60) @(posedge core_clk);
    check("no ivl", 32'(nsamp - n0), 32'd0);
    $display("test periodic done");
    // Every button count, then an out-of-range one
    for (int i = 0; i <= 5; i++) begin
      n0 = npulse;
      i_host.wr(`IOD_OFS_BTN, 32'(i));
      repeat (2) @(posedge core_clk);
      check("btn pulse", 32'(npulse - n0), (i <= 4) ? 32'd1 : 32'd0);
      if (i <= 4) check("btn cnt", {29'h0, button_count}, 32'(i));
    end
    // Configuration code follows the settings
    i_host.rd(`IOD_OFS_CFG, c0);
    i_host.wr(`IOD_OFS_LED, 32'h33);
    i_host.rd(`IOD_OFS_CFG, c1);
    check("cfg moves", 32'(c1 !== c0), 32'h1);
    i_host.wr(`IOD_OFS_LED, 32'h0);
    rchk("cfg back", `IOD_OFS_CFG, c0);
    // LED blink periods at 4 cycles per ms
    check("led drive", 32'(led_drive), 32'h1);
    led_gap(`IOD_LED_NODE_MS * 4);
    sleep_coord <= 1'b1;
    led_gap(`IOD_LED_COORD_MS * 4);
    i_host.wr(`IOD_OFS_LED, 32'h14);
    led_gap(32'h14 * `IOD_LED_UNIT_MS * 4);
    i_host.wr(`IOD_OFS_SEL5, 32'h0);
    repeat (2) @(posedge core_clk);
    check("led off", 32'(led_drive), 32'h0);
    check("led out", 32'(led_out), 32'h0);
    $display("test led done");
    // Signal strength output held 100 ms after a reception
    i_host.wr(`IOD_OFS_HOLD, 32'h1);
    i_host.wr(`IOD_OFS_SEL10, {29'h0, `IOD_SEL_RSSI});
    @(posedge core_clk);
    rx_info <= '{valid: 1'b1, strength: 8'h80};
    @(posedge core_clk);
    rx_info <= '{valid: 1'b0, strength: 8'h00};
    count_hi(1'b0, 300, h);
    check("rssi on", 32'(h > 0), 32'h1);
    repeat (200) @(posedge core_clk);
    count_hi(1'b0, 1024, h);
    check("rssi off", 32'(h), 32'd0);
    rchk("strength", `IOD_OFS_DBM, 32'h80);
    // Statistics: small counts, then saturation held together
    @(posedge core_clk);
    rx_error_ev <= 1'b1;
    rx_good_ev <= 1'b1;
    tx_fail_ev <= 1'b1;
    @(posedge core_clk);
    tx_fail_ev <= 1'b0;
    @(posedge core_clk);
    rx_good_ev <= 1'b0;
    @(posedge core_clk);
    rx_error_ev <= 1'b0;
    rchk("err cnt", `IOD_OFS_ERR, 32'd3);
    rchk("good cnt", `IOD_OFS_GOOD, 32'd2);
    rchk("txf cnt", `IOD_OFS_TXF, 32'd1);
    @(posedge core_clk);
    rx_error_ev <= 1'b1;
    rx_good_ev <= 1'b1;
    tx_fail_ev <= 1'b1;
    repeat (65540) @(posedge core_clk);
    rx_error_ev <= 1'b0;
    rx_good_ev <= 1'b0;
    tx_fail_ev <= 1'b0;
    rchk("err sat", `IOD_OFS_ERR, {16'h0, `IOD_SAT_MAX});
    rchk("good sat", `IOD_OFS_GOOD, {16'h0, `IOD_SAT_MAX});
    rchk("txf sat", `IOD_OFS_TXF, {16'h0, `IOD_SAT_MAX});
    $display("test diagnostics done");
    close_out();
  end
endmodule
